/* inc/mem_pins_pkg.sv */
// Package: constants and carrier types for the memory pin interface
package mem_pins_pkg;

    localparam int ADDR_W    = 11;
    localparam int DATA_W    = 16;
    localparam int COL_W     = 8;
    localparam int PRE_BIT   = 10;
    localparam int WORDS     = 16;
    localparam int WADDR_W   = 4;
    localparam logic [3:0] CMD_NOP   = 4'h7;
    localparam logic [3:0] CMD_ACT   = 4'h3;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam logic [3:0] CMD_MRS   = 4'h0;
    localparam logic [3:0] CMD_INH   = 4'hf;

    // Command request from the core; op uses the CMD_ codes
    typedef struct packed {
        logic              valid;
        logic [3:0]        op;
        logic              chip;
        logic              bank;
        logic [ADDR_W-1:0] addr;
        logic              auto_pre;
        logic              all_banks;
        logic [1:0]        byte_mask;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;

    // Pin bundle, active-low strobes kept at pin level
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              bank;
        logic [1:0]        strobe_a_n;
        logic [1:0]        strobe_b;
        logic              cke_oe;
        logic              we_n;
        logic              row_n;
        logic              col_n;
    } mem_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_CMD  = 2'h1,
        ST_DATA = 2'h3
    } pin_state_t;

endpackage

/* hdl/word_store.sv */
// Small register file holding recent read words, registered read data
`timescale 1ns/100ps
module word_store
    import mem_pins_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               wr_en_in,
    input  wire logic [WADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0]  wr_data_in,
    input  wire logic [WADDR_W-1:0] rd_addr_in,
    output logic      [DATA_W-1:0]  rd_data_out
);
    logic [DATA_W-1:0] mem_reg [WORDS];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_reg[rd_addr_in];
    end
endmodule // word_store

/* hdl/mem_pin_interface.sv */
// Pin personality for the SDRAM or EDO external memory port
// Functional notes
// - Activate drives the whole row on all eleven address lines
// - Read/write puts column on low eight lines, bit ten asks auto precharge
// - Precharge bit ten high precharges all banks, else addressed bank
// - Bank address output picks the bank of each command
// - Mode register load puts the twelfth mode bit on bank address
// - Byte masks act as write masks on writes, output enables on reads
// - Mask zero governs low data byte, mask one the high byte
// - Command is coded on row, column, write enable and chip select
// - One chip select low for the addressed part, the other high
// - Clock enable low with a NOP enters precharge power-down
// - Clock enable high runs the memory clock on its output
// - EDO uses the shared strobe pairs as row and column strobes
// - EDO shared enable pin is output enable; SDRAM-only pins idle
`timescale 1ns/100ps
module mem_pin_interface
    import mem_pins_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    input  wire logic              edo_mode_in,
    input  wire logic              power_down_in,
    input  wire mem_req_t          req_in,
    input  wire logic [WADDR_W-1:0] rd_index_in,
    output logic                   busy_out,
    output logic                   edo_active_out,
    output mem_pins_t              pins_out,
    output logic                   sdram_clock_out,
    output logic [DATA_W-1:0]      data_out,
    output logic [DATA_W-1:0]      data_oe_out,
    input  wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0]      rd_word_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pin_state_t        state_reg,  state_next;
    logic              edo_reg,    edo_next;
    mem_pins_t         pins_reg,   pins_next;
    logic              clk_reg,    clk_next;
    logic [DATA_W-1:0] dout_reg,   dout_next;
    logic [DATA_W-1:0] doe_reg,    doe_next;
    logic              cap_reg,    cap_next;
    logic [1:0]        mask_reg,   mask_next;
    logic [WADDR_W-1:0] wptr_reg,  wptr_next;
    logic              rd_pend_reg, rd_pend_next;
    logic              busy_reg,   busy_next;
    logic [DATA_W-1:0] cap_data;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        edo_next     = edo_reg;
        pins_next    = pins_reg;
        dout_next    = dout_reg;
        doe_next     = '0;
        cap_next     = 1'b0;
        mask_next    = mask_reg;
        wptr_next    = wptr_reg;
        rd_pend_next = 1'b0;
        // Memory clock toggles only while enabled
        clk_next     = (!edo_reg && pins_reg.cke_oe) ? ~clk_reg : 1'b0;
        case (state_reg)
            ST_IDLE: begin
                // Mode swap mid-access would corrupt strobes
                edo_next = edo_mode_in;
                if (edo_reg) begin
                    pins_next.strobe_a_n = 2'h3;
                    pins_next.strobe_b   = 2'h3;
                    pins_next.cke_oe     = 1'b1;
                    pins_next.we_n       = 1'b1;
                end else begin
                    pins_next.strobe_a_n = 2'h3;
                    pins_next.strobe_b   = 2'h0;
                    {pins_next.row_n, pins_next.col_n, pins_next.we_n} =
                        CMD_NOP[2:0];
                    pins_next.cke_oe     = ~power_down_in;
                end
                if (req_in.valid && !power_down_in) begin
                    state_next = ST_CMD;
                end
            end
            ST_CMD: begin
                if (edo_reg) begin
                    pins_next.addr = req_in.addr;
                    pins_next.strobe_a_n = req_in.chip ? 2'h1 : 2'h2;
                    pins_next.we_n = (req_in.op != CMD_WRITE);
                    pins_next.cke_oe = (req_in.op != CMD_READ);
                end else begin
                    // Chip select low only for the addressed part
                    pins_next.strobe_a_n = req_in.chip ? 2'h1 : 2'h2;
                    {pins_next.row_n, pins_next.col_n, pins_next.we_n} =
                        req_in.op[2:0];
                    pins_next.bank = req_in.bank;
                    pins_next.addr = req_in.addr;
                    if (req_in.op == CMD_READ || req_in.op == CMD_WRITE) begin
                        pins_next.addr = '0;
                        pins_next.addr[COL_W-1:0] =
                            req_in.addr[COL_W-1:0];
                        pins_next.addr[PRE_BIT] = req_in.auto_pre;
                        // Mask bit zero low byte, bit one high byte
                        pins_next.strobe_b = req_in.byte_mask;
                    end
                    if (req_in.op == CMD_PRE) begin
                        pins_next.addr[PRE_BIT] = req_in.all_banks;
                    end
                end
                mask_next = req_in.byte_mask;
                if (req_in.op == CMD_WRITE) begin
                    dout_next = req_in.wdata;
                    doe_next  = {{8{~req_in.byte_mask[1]}},
                                 {8{~req_in.byte_mask[0]}}};
                end
                rd_pend_next = (req_in.op == CMD_READ);
                state_next   = ST_DATA;
            end
            ST_DATA: begin
                if (edo_reg) begin
                    pins_next.strobe_b = ~(~mask_reg & 2'h3);
                end else begin
                    pins_next.strobe_a_n = 2'h3;
                    {pins_next.row_n, pins_next.col_n, pins_next.we_n} =
                        CMD_NOP[2:0];
                end
                cap_next   = rd_pend_reg;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (edo_reg) begin
            // SDRAM-only pins parked
            pins_next.bank  = 1'b0;
            pins_next.row_n = 1'b1;
            pins_next.col_n = 1'b1;
        end
        if (cap_reg) begin
            wptr_next = wptr_reg + 1'b1;
        end
        busy_next = (state_next != ST_IDLE);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg   <= ST_IDLE;
            edo_reg     <= 1'b0;
            pins_reg    <= '1;
            clk_reg     <= 1'b0;
            dout_reg    <= '0;
            doe_reg     <= '0;
            cap_reg     <= 1'b0;
            mask_reg    <= '0;
            wptr_reg    <= '0;
            rd_pend_reg <= 1'b0;
            busy_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            edo_reg     <= edo_next;
            pins_reg    <= pins_next;
            clk_reg     <= clk_next;
            dout_reg    <= dout_next;
            doe_reg     <= doe_next;
            cap_reg     <= cap_next;
            mask_reg    <= mask_next;
            wptr_reg    <= wptr_next;
            rd_pend_reg <= rd_pend_next;
            busy_reg    <= busy_next;
        end
    end

    // Masked read bytes stored as zero
    for (genvar g = 0; g < 2; g++) begin : g_byte
        assign cap_data[g*8 +: 8] = mask_reg[g] ? 8'h00 : data_in[g*8 +: 8];
    end

    word_store u_store (
        .clk_in      (clk_in),
        .wr_en_in    (cap_reg),
        .wr_addr_in  (wptr_reg),
        .wr_data_in  (cap_data),
        .rd_addr_in  (rd_index_in),
        .rd_data_out (rd_word_out)
    );

    assign busy_out        = busy_reg;
    assign edo_active_out  = edo_reg;
    assign pins_out        = pins_reg;
    assign sdram_clock_out = clk_reg;
    assign data_out        = dout_reg;
    assign data_oe_out     = doe_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking pins_cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence cmd_issue_s;
        state_reg == ST_CMD && !edo_reg;
    endsequence

    sequence pre_issue_s;
        cmd_issue_s and req_in.op == CMD_PRE;
    endsequence

    sequence read_issue_s;
        cmd_issue_s and req_in.op == CMD_READ;
    endsequence

    mode_hold_a: assert property (
        state_reg != ST_IDLE |=> $stable(edo_reg))
        else $error("Mode changed during access");
    chip_one_a: assert property (
        cmd_issue_s |=> ^pins_out.strobe_a_n)
        else $error("Chip selects not exactly one low");
    cmd_code_a: assert property (
        cmd_issue_s |=> {pins_out.row_n, pins_out.col_n, pins_out.we_n}
            == $past(req_in.op[2:0]))
        else $error("Command code wrong");
    bank_out_a: assert property (
        cmd_issue_s |=> pins_out.bank == $past(req_in.bank))
        else $error("Bank address wrong");
    pre_all_a: assert property (
        pre_issue_s |=> pins_out.addr[PRE_BIT] == $past(req_in.all_banks))
        else $error("Precharge all bit wrong");
    col_addr_a: assert property (
        read_issue_s |=>
            pins_out.addr[COL_W-1:0] == $past(req_in.addr[COL_W-1:0]))
        else $error("Column address wrong");
    edo_park_a: assert property (
        edo_reg ##1 edo_reg |-> pins_out.row_n && !sdram_clock_out)
        else $error("SDRAM pins active in EDO mode");
    pdown_a: assert property (
        state_reg == ST_IDLE && !edo_reg && power_down_in |=>
            !pins_out.cke_oe && pins_out.strobe_a_n == 2'h3)
        else $error("Power-down entry wrong");
endmodule // mem_pin_interface

/* sim/mem_model.sv */
// Behavioural SDRAM or EDO memory part answering reads on the data bus
`timescale 1ns/100ps
module mem_model
    import mem_pins_pkg::*;
#(
    parameter logic [DATA_W-1:0] READ_WORD = 16'hc35a
)(
    input  wire logic              clk_in,
    input  wire logic              edo_in,
    input  wire mem_pins_t         pins_in,
    output logic [DATA_W-1:0]      dq_out
);
    logic [DATA_W-1:0] last_word = '0;
    logic [DATA_W-1:0] bus_word  = '1;
    logic              rd_late   = 1'b0;
    logic              sel_seen;
    logic              rd_seen;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign sel_seen = (pins_in.strobe_a_n != 2'b11);
    assign rd_seen  = edo_in ? (sel_seen && !pins_in.cke_oe)
        : (sel_seen && pins_in.cke_oe &&
           {pins_in.row_n, pins_in.col_n, pins_in.we_n} == 3'h5);

    // ------------------------------------------------------------
    // Data bus
    // ------------------------------------------------------------
    // One cycle of read latency; the word stands one cycle in SDRAM mode, two in EDO mode
    // Released bus flips, so a stale word can never pass for read data
    always @(negedge clk_in) begin
        rd_late <= rd_seen;
        if (rd_late) begin
            bus_word  <= READ_WORD;
            last_word <= READ_WORD;
        end else begin
            bus_word <= ~last_word;
        end
    end
    assign dq_out = bus_word;
endmodule // mem_model

/* sim/testbench.sv */
// Self-checking bench for the memory pin personality block
`timescale 1ns/100ps
module testbench;
    import mem_pins_pkg::*;
    localparam logic [15:0] RD_WORD = 16'hc35a;
    logic               clk_in        = 1'b0;
    logic               reset_in      = 1'b1;
    logic               edo_mode_in   = 1'b0;
    logic               power_down_in = 1'b0;
    mem_req_t           req_in        = '0;
    logic [WADDR_W-1:0] rd_index_in   = '0;
    logic               busy_out;
    logic               edo_active_out;
    logic               sdram_clock_out;
    mem_pins_t          pins_out;
    mem_pins_t          cap;
    logic [DATA_W-1:0]  data_out;
    logic [DATA_W-1:0]  data_oe_out;
    logic [DATA_W-1:0]  data_in;
    logic [DATA_W-1:0]  rd_word_out;
    logic [DATA_W-1:0]  cap_data;
    logic [DATA_W-1:0]  cap_oe;
    int                 err_total = 0;
    int                 n_tests   = 0;

    always #2.5 clk_in = ~clk_in;

    mem_pin_interface u_dut (.clk_in(clk_in), .reset_in(reset_in),
        .edo_mode_in(edo_mode_in), .power_down_in(power_down_in),
        .req_in(req_in), .rd_index_in(rd_index_in), .busy_out(busy_out),
        .edo_active_out(edo_active_out), .pins_out(pins_out),
        .sdram_clock_out(sdram_clock_out), .data_out(data_out),
        .data_oe_out(data_oe_out), .data_in(data_in),
        .rd_word_out(rd_word_out));
    mem_model #(.READ_WORD(RD_WORD)) u_mem (.clk_in(clk_in),
        .edo_in(edo_active_out), .pins_in(pins_out), .dq_out(data_in));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // Request held until the command shows at the pins
    task automatic issue(input logic [3:0] op, input logic chip, bank,
        input logic [10:0] addr, input logic ap, ab,
        input logic [1:0] mask, input logic [15:0] wd);
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < 20) begin
            cyc(1);
            n++;
        end
        req_in = '{valid:1'b1, op:op, chip:chip, bank:bank, addr:addr,
            auto_pre:ap, all_banks:ab, byte_mask:mask, wdata:wd};
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (pins_out.strobe_a_n === 2'b11 && n < 6);
        cap = pins_out;
        cap_data = data_out;
        cap_oe = data_oe_out;
        req_in.valid = 1'b0;
        chk("command issued", 16'h1, 16'(n < 6));
        chk("busy in access", 16'h1, 16'(busy_out));
    endtask

    function automatic logic [15:0] code();
        return 16'({cap.row_n, cap.col_n, cap.we_n});
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_act();
        for (int c = 0; c < 2; c++) begin
            issue(CMD_ACT, c[0], ~c[0], c ? 11'h400 : 11'h7ff, 0, 0, 0, 0);
            chk("act row", c ? 16'h400 : 16'h7ff, 16'(cap.addr));
            chk("act bank", c ? 16'h0 : 16'h1, 16'(cap.bank));
            chk("act select", c ? 16'h1 : 16'h2, 16'(cap.strobe_a_n));
            chk("act code", 16'h3, code());
        end
    endtask

    task automatic t_rw();
        issue(CMD_READ, 0, 1, 11'h0a5, 1, 0, 2'b10, 0);
        chk("read col", 16'h4a5, 16'(cap.addr));
        chk("read code", 16'h5, code());
        chk("read mask", 16'h2, 16'(cap.strobe_b));
        issue(CMD_READ, 1, 0, 11'h03c, 0, 0, 2'b01, 0);
        chk("read no auto", 16'h03c, 16'(cap.addr));
        cyc(3);
        chk("read word0", {8'h00, RD_WORD[7:0]}, rd_word_out);
        rd_index_in = 4'h1;
        cyc(2);
        chk("read word1", {RD_WORD[15:8], 8'h00}, rd_word_out);
        issue(CMD_WRITE, 1, 0, 11'h43c, 0, 0, 2'b01, 16'hbeef);
        chk("write col", 16'h03c, 16'(cap.addr));
        chk("write code", 16'h4, code());
        chk("write data", 16'hbeef, cap_data);
        chk("write hi oe", 16'hff, 16'(cap_oe[15:8]));
        chk("write mask", 16'h1, 16'(cap.strobe_b));
        cyc(1);
        chk("write oe off", 16'h0, data_oe_out);
    endtask

    task automatic t_pre_mrs();
        issue(CMD_PRE, 0, 0, 11'h000, 0, 1, 0, 0);
        chk("pre all", 16'h1, 16'(cap.addr[PRE_BIT]));
        chk("pre code", 16'h2, code());
        issue(CMD_PRE, 0, 1, 11'h7ff, 0, 0, 0, 0);
        chk("pre one", 16'h0, 16'(cap.addr[PRE_BIT]));
        chk("pre bank", 16'h1, 16'(cap.bank));
        issue(CMD_MRS, 0, 1, 11'h023, 0, 0, 0, 0);
        chk("mode bit", 16'h1, 16'(cap.bank));
        chk("mode code", 16'h0, code());
    endtask

    task automatic t_power();
        logic s0;
        s0 = sdram_clock_out;
        cyc(1);
        chk("clock runs", {15'h0, ~s0}, 16'(sdram_clock_out));
        chk("cke high", 16'h1, 16'(pins_out.cke_oe));
        power_down_in = 1'b1;
        cyc(3);
        cap = pins_out;
        chk("pd cke", 16'h0, 16'(cap.cke_oe));
        chk("pd nop", 16'h7, code());
        req_in = '{valid:1'b1, op:CMD_ACT, chip:0, bank:0, addr:1, default:0};
        cyc(4);
        chk("pd refused", 16'h3, 16'(pins_out.strobe_a_n));
        chk("pd clock", 16'h0, 16'(sdram_clock_out));
        req_in.valid = 1'b0;
        power_down_in = 1'b0;
        cyc(3);
    endtask

    task automatic t_edo();
        issue(CMD_READ, 0, 0, 11'h011, 0, 0, 0, 0);
        edo_mode_in = 1'b1;
        chk("mode held", 16'h0, 16'(edo_active_out));
        cyc(4);
        chk("mode taken", 16'h1, 16'(edo_active_out));
        chk("edo no clock", 16'h0, 16'(sdram_clock_out));
        issue(CMD_READ, 1, 1, 11'h022, 0, 0, 2'b01, 0);
        chk("edo row strobe", 16'h1, 16'(cap.strobe_a_n));
        chk("edo oe", 16'h0, 16'(cap.cke_oe));
        chk("edo idle pins", 16'h3, 16'({cap.row_n, cap.col_n}));
        cyc(1);
        chk("edo col strobe", 16'h1, 16'(pins_out.strobe_b));
        rd_index_in = 4'h3;
        cyc(2);
        chk("edo word", {RD_WORD[15:8], 8'h00}, rd_word_out);
    endtask

    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        cyc(12);
        chk("reset pins", 16'hffff, 16'(pins_out[15:0]));
        chk("reset oe", 16'h0, data_oe_out);
        reset_in = 1'b0;
        cyc(1);
        t_act();
        t_rw();
        t_pre_mrs();
        t_power();
        t_edo();
        summarize();
    end

    // Whole run is under a hundred cycles; this bound is generous
    initial begin
        #20000;
        err_total++;
        summarize();
    end
endmodule // testbench
